// File: rtl/guard_soak_timer.sv
// Purpose: Guard soak timer for one reference input
// Assumes: Monitor flags synchronous to clk_in
// Notes: Counts system clock cycles; a broken condition restarts the wait
`include "ref_qualify_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module guard_soak_timer
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire ref_qualify_pkg::mon_flags_s flags_in,
    input wire logic [1:0] fail_sel_in,
    input wire logic [1:0] recover_sel_in,
    output logic soak_fail_out
);
    import ref_qualify_pkg::*;

    // Cycle count for a disqualify select code
    function automatic logic [`RQ_CNT_W-1:0] fail_cycles(input logic [1:0] sel);
        unique case (sel)
            2'b00: fail_cycles = `RQ_CNT_W'(`RQ_T_MIN_CYC);
            2'b01: fail_cycles = `RQ_CNT_W'(`RQ_MS_TO_CYC(`RQ_T_SHORT_MS));
            2'b10: fail_cycles = `RQ_CNT_W'(`RQ_MS_TO_CYC(`RQ_T_MID_MS));
            2'b11: fail_cycles = `RQ_CNT_W'(`RQ_MS_TO_CYC(`RQ_T_LONG_MS));
        endcase
    endfunction : fail_cycles

    // Multiplier for a requalify select code
    function automatic logic [3:0] recover_mult(input logic [1:0] sel);
        unique case (sel)
            2'b00: recover_mult = `RQ_MULT_0;
            2'b01: recover_mult = `RQ_MULT_1;
            2'b10: recover_mult = `RQ_MULT_2;
            2'b11: recover_mult = `RQ_MULT_3;
        endcase
    endfunction : recover_mult

    soak_state_e state_q; // Qualification state
    soak_state_e state_d;
    logic [`RQ_CNT_W-1:0] cnt_q; // Cycles spent in the current wait
    logic [`RQ_CNT_W-1:0] cnt_d;
    wire logic fault = flags_in.coarse_rate_check | flags_in.single_period_check; // R2 R11
    wire logic [`RQ_CNT_W-1:0] fail_lim = fail_cycles(fail_sel_in); // R1
    // Product fits: 8 x 2.5 s of cycles is under 2^35
    wire logic [`RQ_CNT_W-1:0] rec_lim = `RQ_CNT_W'(fail_lim * recover_mult(recover_sel_in)); // R3
    wire logic fail_done = (cnt_q + `RQ_CNT_W'(1)) >= fail_lim;
    wire logic rec_done = (cnt_q + `RQ_CNT_W'(1)) >= rec_lim;

    // Next state; a lapse of the condition restarts the wait
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q + `RQ_CNT_W'(1);
        unique case (state_q)
            ST_QUALIFIED:
            begin
                cnt_d = '0;
                if (fault)
                    state_d = ST_FAIL_WAIT; // R2
            end
            ST_FAIL_WAIT:
            begin
                if (!fault)
                begin
                    state_d = ST_QUALIFIED; // R12
                    cnt_d = '0;
                end
                else if (fail_done)
                begin
                    state_d = ST_DISQUALIFIED;
                    cnt_d = '0;
                end
            end
            ST_DISQUALIFIED:
            begin
                cnt_d = '0;
                if (!fault)
                    state_d = ST_RECOVER_WAIT; // R4
            end
            ST_RECOVER_WAIT:
            begin
                if (fault)
                begin
                    state_d = ST_DISQUALIFIED; // R12
                    cnt_d = '0;
                end
                else if (rec_done)
                begin
                    state_d = ST_QUALIFIED;
                    cnt_d = '0;
                end
            end
        endcase
    end

    // State registers, frozen by clock enable
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            state_q <= ST_QUALIFIED;
            cnt_q <= '0;
        end
        else if (ce_in)
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
        end
    end

    // Failed while disqualified or waiting to recover
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            soak_fail_out <= 1'b0;
        else if (ce_in)
            soak_fail_out <= state_d[1];
    end

endmodule : guard_soak_timer

`default_nettype wire

// File: rtl/ref_qualify_timer_regs.sv
// Purpose: Guard soak delay, status freeze and reference 0 base rate registers
// Assumes: Byte-wide register port from the serial management front end, synchronous to clk_in
// Notes: Registers sit at their printed byte addresses
//
// How it works
// R1 - Two-bit select picks disqualify delay
// R2 - Disqualify wait starts on either flag
// R3 - Requalify delay is disqualify times 2/4/6/8
// R4 - Requalify wait needs both flags clear
// R5 - Reference n uses bits 2n+1:2n
// R6 - Delay registers reset to aa and 55
// R7 - Writing 01 freezes sticky status updates
// R8 - Writing 00 resumes sticky status updates
// R9 - Base rate is 16-bit hertz value
// R10 - Host writes high byte at lower address
// R11 - Flags come from the reference monitors
// R12 - Lapsed condition restarts timer, state unchanged; the code drops back to ST_QUALIFIED or ST_DISQUALIFIED instead
`include "ref_qualify_defines.svh"
`timescale 1ns/1ps
`default_nettype none

module ref_qualify_timer_regs
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire ref_qualify_pkg::reg_req_s req_in,
    output logic [7:0] rdata_out,
    output logic rvalid_out,
    input wire ref_qualify_pkg::mon_flags_s [3:0] flags_in,
    output logic [3:0] soak_fail_out,
    output logic status_freeze_out,
    output logic [15:0] ref0_base_rate_out
);
    import ref_qualify_pkg::*;

    logic [7:0] fail_delay_q; // guard_soak_fail_delay
    logic [7:0] recover_delay_q; // guard_soak_recover_delay
    logic [7:0] freeze_ctrl_q; // status_freeze_control
    logic [15:0] base_rate_q; // ref0_base_rate
    logic freeze_q; // Freeze level seen by sticky status logic
    logic [7:0] rdata_q;
    logic rvalid_q;

    // Address decode
    wire logic hit_fail = req_in.addr == `RQ_ADDR_FAIL_DELAY;
    wire logic hit_rec = req_in.addr == `RQ_ADDR_RECOVER_DELAY;
    wire logic hit_frz = req_in.addr == `RQ_ADDR_FREEZE;
    wire logic hit_bhi = req_in.addr == `RQ_ADDR_BASE_HI;
    wire logic hit_blo = req_in.addr == `RQ_ADDR_BASE_LO;
    wire logic wr_en = req_in.wr & ce_in;

    // Read mux; unmapped addresses read zero
    wire logic [7:0] rd_mux =
        hit_fail ? fail_delay_q :
        hit_rec ? recover_delay_q :
        hit_frz ? freeze_ctrl_q :
        hit_bhi ? base_rate_q[15:8] : // R10
        hit_blo ? base_rate_q[7:0] :
        8'h00;

    // Delay selects and freeze register
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            fail_delay_q <= `RQ_RST_FAIL_DELAY; // R6
            recover_delay_q <= `RQ_RST_RECOVER_DELAY; // R6
            freeze_ctrl_q <= `RQ_RST_FREEZE;
        end
        else if (wr_en)
        begin
            if (hit_fail)
                fail_delay_q <= req_in.wdata;
            if (hit_rec)
                recover_delay_q <= req_in.wdata;
            if (hit_frz)
                freeze_ctrl_q <= req_in.wdata;
        end
    end

    // Freeze follows only the two defined codes; other values keep the last state
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            freeze_q <= 1'b0;
        else if (wr_en && hit_frz)
        begin
            if (req_in.wdata == `RQ_FREEZE_ON)
                freeze_q <= 1'b1; // R7
            else if (req_in.wdata == `RQ_FREEZE_OFF)
                freeze_q <= 1'b0; // R8
        end
    end

    // Base rate, big endian byte halves, each byte applied on its own write
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
            base_rate_q <= `RQ_RST_BASE_RATE;
        else if (wr_en)
        begin
            if (hit_bhi)
                base_rate_q[15:8] <= req_in.wdata; // R9 R10
            if (hit_blo)
                base_rate_q[7:0] <= req_in.wdata; // R9 R10
        end
    end

    // Registered read data, one cycle after the read strobe
    always_ff @(posedge clk_in)
    begin
        if (!rstn_in)
        begin
            rdata_q <= 8'h00;
            rvalid_q <= 1'b0;
        end
        else if (ce_in)
        begin
            rvalid_q <= req_in.rd;
            if (req_in.rd)
                rdata_q <= rd_mux;
        end
    end

    assign rdata_out = rdata_q;
    assign rvalid_out = rvalid_q;
    assign status_freeze_out = freeze_q;
    assign ref0_base_rate_out = base_rate_q;

    // One guard soak timer per reference
    genvar g;
    generate
        for (g = 0; g < `RQ_NUM_REFS; g++)
        begin : g_ref
            guard_soak_timer u_timer
            (
                .clk_in(clk_in),
                .rstn_in(rstn_in),
                .ce_in(ce_in),
                .flags_in(flags_in[g]), // R11
                .fail_sel_in(fail_delay_q[2*g +: `RQ_SEL_W]), // R5
                .recover_sel_in(recover_delay_q[2*g +: `RQ_SEL_W]), // R5
                .soak_fail_out(soak_fail_out[g])
            );
        end
    endgenerate

endmodule : ref_qualify_timer_regs

`default_nettype wire

// File: shared/ref_qualify_defines.svh
// Purpose: Offsets, field positions, reset values and timing counts for the reference qualify register bank
// Assumes: 125 MHz system clock, byte-wide register port
// Notes: Times are given in their own units, cycle counts derived from them
`ifndef REF_QUALIFY_DEFINES_SVH
`define REF_QUALIFY_DEFINES_SVH

`define RQ_ADDR_FAIL_DELAY 7'h0b
`define RQ_ADDR_RECOVER_DELAY 7'h0c
`define RQ_ADDR_FREEZE 7'h0d
`define RQ_ADDR_BASE_HI 7'h10
`define RQ_ADDR_BASE_LO 7'h11

`define RQ_RST_FAIL_DELAY 8'haa
`define RQ_RST_RECOVER_DELAY 8'h55
`define RQ_RST_FREEZE 8'h00
`define RQ_RST_BASE_RATE 16'h9c40

`define RQ_FREEZE_ON 8'h01
`define RQ_FREEZE_OFF 8'h00

`define RQ_SEL_W 2
`define RQ_NUM_REFS 4

`define RQ_CLK_HZ 125000000
`define RQ_T_MIN_CYC 1
`define RQ_T_SHORT_MS 10
`define RQ_T_MID_MS 50
`define RQ_T_LONG_MS 2500
`define RQ_MS_TO_CYC(ms) ((ms) * (`RQ_CLK_HZ / 1000))

`define RQ_MULT_0 4'd2
`define RQ_MULT_1 4'd4
`define RQ_MULT_2 4'd6
`define RQ_MULT_3 4'd8

`define RQ_CNT_W 35

`endif

// File: shared/ref_qualify_pkg.sv
// Purpose: Types shared by the reference qualify register bank
// Assumes: Constants live in ref_qualify_defines.svh
// Notes: Holds types only
package ref_qualify_pkg;

    // Register port request from the serial management front end
    typedef struct packed {
        logic wr;
        logic rd;
        logic [6:0] addr;
        logic [7:0] wdata;
    } reg_req_s;

    // Per-reference monitor flags
    typedef struct packed {
        logic coarse_rate_check;
        logic single_period_check;
    } mon_flags_s;

    // Qualification timer states
    typedef enum logic [1:0] {
        ST_QUALIFIED = 2'b00,
        ST_FAIL_WAIT = 2'b01,
        ST_DISQUALIFIED = 2'b10,
        ST_RECOVER_WAIT = 2'b11
    } soak_state_e;

endpackage : ref_qualify_pkg

// File: verif/host_port_model.sv
// Purpose: Host side of the byte register port
// Assumes: Requests held until the taking edge
// Notes: Released lines show the inverse of the last value
`timescale 1ns/1ps
`default_nettype none
module host_port_model
(
    input wire logic clk_in,
    output var ref_qualify_pkg::reg_req_s req_out,
    input wire logic [7:0] rdata_in,
    input wire logic rvalid_in
);
    import ref_qualify_pkg::*;
    // Idle port at time zero
    initial req_out = '0;
    // One byte write
    task automatic wr(input logic [6:0] a, input logic [7:0] x);
        @(posedge clk_in);
        req_out.addr <= a;
        req_out.wdata <= x;
        req_out.wr <= 1'b1;
        @(posedge clk_in);
        req_out.wr <= 1'b0;
        req_out.addr <= ~a;
        req_out.wdata <= ~x;
    endtask : wr
    // One byte read, answer taken one edge later
    task automatic rd(input logic [6:0] a, output logic [7:0] x, output logic v);
        @(posedge clk_in);
        req_out.addr <= a;
        req_out.rd <= 1'b1;
        @(posedge clk_in);
        req_out.rd <= 1'b0;
        req_out.addr <= ~a;
        @(posedge clk_in);
        v = rvalid_in;
        x = rdata_in;
    endtask : rd
endmodule : host_port_model
`default_nettype wire

// File: verif/ref_qualify_checker.sv
// Purpose: Port assertions for the qualify register bank
// Assumes: One clock, synchronous active low reset
// Notes: Watches reference 0 timer only, to save space
`timescale 1ns/1ps
`default_nettype none
module ref_qualify_checker
(
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire ref_qualify_pkg::reg_req_s req_in,
    input wire logic [7:0] rdata_out,
    input wire logic rvalid_out,
    input wire ref_qualify_pkg::mon_flags_s [3:0] flags_in,
    input wire logic [3:0] soak_fail_out,
    input wire logic status_freeze_out,
    input wire logic [15:0] ref0_base_rate_out
);
    import ref_qualify_pkg::*;
    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (!rstn_in);
    // Requests the bank really takes
    wire rd_t = ce_in && req_in.rd;
    wire wr_t = ce_in && req_in.wr;
    // Taken write of one value to the freeze control
    sequence s_frz(logic [7:0] v);
        wr_t && req_in.addr == 7'h0d && req_in.wdata == v;
    endsequence
    property p_rd_hi;
        rd_t && req_in.addr == 7'h10 |=> rvalid_out && rdata_out == 8'($past(ref0_base_rate_out) >> 8);
    endproperty
    property p_rd_lo;
        rd_t && req_in.addr == 7'h11 |=> rvalid_out && rdata_out == 8'($past(ref0_base_rate_out));
    endproperty
    property p_wr_hi;
        wr_t && req_in.addr == 7'h10 |=> ref0_base_rate_out[15:8] == $past(req_in.wdata);
    endproperty
    property p_frz_on;
        s_frz(8'h01) |=> status_freeze_out;
    endproperty
    property p_frz_off;
        s_frz(8'h00) |=> !status_freeze_out;
    endproperty
    // Reset itself must not mask this one
    property p_rst;
        disable iff (1'b0) !rstn_in |=> ref0_base_rate_out == 16'h9c40 && !status_freeze_out;
    endproperty
    property p_rise;
        $rose(soak_fail_out[0]) |-> $past(flags_in[0]) != '0 || $past(flags_in[0], 2) != '0;
    endproperty
    // Shortest recovery is three clear samples; only the last two are checked
    property p_fall;
        $fell(soak_fail_out[0]) |-> $past(flags_in[0]) == '0 && $past(flags_in[0], 2) == '0;
    endproperty
    property p_hold;
        soak_fail_out[0] && flags_in[0] != '0 |=> soak_fail_out[0];
    endproperty
    a_rd_hi: assert property (p_rd_hi) else $error("high byte read");
    a_rd_lo: assert property (p_rd_lo) else $error("low byte read");
    a_wr_hi: assert property (p_wr_hi) else $error("high byte write");
    a_frz_on: assert property (p_frz_on) else $error("freeze not set");
    a_frz_off: assert property (p_frz_off) else $error("freeze not cleared");
    a_rst: assert property (p_rst) else $error("reset value");
    a_rise: assert property (p_rise) else $error("fail without fault");
    a_fall: assert property (p_fall) else $error("early recovery");
    a_hold: assert property (p_hold) else $error("fail dropped in fault");
endmodule : ref_qualify_checker
bind ref_qualify_timer_regs ref_qualify_checker chk (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
    .req_in(req_in), .rdata_out(rdata_out), .rvalid_out(rvalid_out), .flags_in(flags_in),
    .soak_fail_out(soak_fail_out), .status_freeze_out(status_freeze_out), .ref0_base_rate_out(ref0_base_rate_out));
`default_nettype wire

// File: verif/tb_top.sv
// Purpose: Self-checking bench for the qualify register bank
// Assumes: Host model on the register port, bench drives monitor flags
// Notes: Select 00 keeps soak waits to a few cycles
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import ref_qualify_pkg::*;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ce_in = 1'b1; // Dropped once to show that a freeze write is not taken and the faulted reference 1 timer holds
    mon_flags_s [3:0] flags = '0;
    reg_req_s req;
    logic [7:0] d;
    logic v;
    logic [3:0] soak;
    logic frz;
    logic mfrz = 1'b0;
    logic [15:0] base;
    int n_fail = 0;
    int cmp_count = 0;
    int n;
    int mreg [int]; // Byte register model by address
    int rates [9] = '{16'h03e8, 16'h07d0, 16'h1388, 16'h186a, 16'h1f40, 16'h2710, 16'h30d4, 16'h61a8, 16'h9c40};
    // 125 MHz
    always #4 clk_in = ~clk_in;
    ref_qualify_timer_regs uut (.clk_in(clk_in), .rstn_in(rstn_in), .ce_in(ce_in), .req_in(req),
        .rdata_out(d), .rvalid_out(v), .flags_in(flags), .soak_fail_out(soak),
        .status_freeze_out(frz), .ref0_base_rate_out(base));
    host_port_model host (.clk_in(clk_in), .req_out(req), .rdata_in(d), .rvalid_in(v));
    task automatic chk(input logic ok, input string msg);
        cmp_count++;
        if (ok !== 1'b1)
        begin
            n_fail++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk
    // Write, update the model, compare outputs
    task automatic mwr(input int a, input int x);
        host.wr(7'(a), 8'(x));
        if (mreg.exists(a))
            mreg[a] = x & 255;
        if (a == 13 && x < 2)
            mfrz = (x == 1);
        #1;
        chk(frz === mfrz && base === 16'((mreg[16] << 8) | mreg[17]), "write effect");
    endtask : mwr
    // Read and compare; unmapped reads give zero
    task automatic rchk(input int a);
        logic [7:0] rd;
        logic rv;
        host.rd(7'(a), rd, rv);
        chk(rv === 1'b1 && rd === 8'(mreg.exists(a) ? mreg[a] : 0), "read back");
    endtask : rchk
    // Fault, clear, short refault, then time the recovery
    task automatic soak_run(input int r);
        @(posedge clk_in);
        flags[r] <= (r % 2) ? 2'b01 : 2'b10;
        repeat (4) @(posedge clk_in);
        chk(soak[r] === 1'b1, "fail not raised");
        flags[r] <= '0;
        @(posedge clk_in);
        flags[r] <= 2'b11;
        @(posedge clk_in);
        flags[r] <= '0;
        n = 0;
        while (soak[r] !== 1'b0 && n < 20)
        begin
            @(posedge clk_in);
            #1;
            n++;
        end
        // One edge to enter the wait, then exactly the multiple of the one-cycle delay
        chk(n == 2 * (r + 1) + 1, "recovery time");
    endtask : soak_run
    task automatic end_of_test();
        $display("compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask : end_of_test
    // Watchdog against a hang
    initial
    begin
        repeat (5000) @(posedge clk_in);
        n_fail++;
        end_of_test();
    end
    // Main sequence
    initial
    begin
        void'($urandom(32'h420b));
        mreg[11] = 8'haa;
        mreg[12] = 8'h55;
        mreg[13] = 0;
        mreg[16] = 8'h9c;
        mreg[17] = 8'h40;
        repeat (10) @(posedge clk_in);
        rstn_in <= 1'b1;
        foreach (rates[i])
            if (i > 10 || i < 6)
                rchk(i == 5 ? 14 : (i < 3 ? 11 + i : 13 + i));
        for (int i = 0; i < 6; i++)
        begin
            n = rates[$urandom_range(8)];
            mwr(16, n >> 8);
            mwr(17, n);
            mwr(11 + $urandom_range(1), $urandom_range(255));
            mwr(13, $urandom_range(1));
            mwr(14, $urandom_range(255));
            rchk(11 + $urandom_range(1));
            rchk(16 + $urandom_range(1));
            rchk(14);
        end
        mwr(13, 1);
        mwr(13, 8'h5a);
        mwr(13, 0);
        mwr(11, 0);
        mwr(12, 8'he4);
        @(posedge clk_in);
        flags[0] <= 2'b11;
        repeat (4) @(posedge clk_in);
        flags[0] <= 2'b01;
        repeat (12) @(posedge clk_in);
        chk(soak[0] === 1'b1, "recovered with one flag");
        flags[0] <= '0;
        repeat (12) @(posedge clk_in);
        // Enable low: a freeze write is not taken and a faulted timer holds still
        ce_in <= 1'b0;
        flags[1] <= 2'b11;
        host.wr(7'h0d, 8'h01);
        repeat (4) @(posedge clk_in);
        chk(frz === mfrz && soak[1] === 1'b0, "state moved with enable low");
        flags[1] <= '0;
        ce_in <= 1'b1;
        rchk(13);
        for (int r = 0; r < 4; r++)
            soak_run(r);
        end_of_test();
    end
endmodule : tb_top
`default_nettype wire
